// >>> src/sfspi_pkg.sv
/*
 Constants and types for the serial flash front end.
 Assumes a core clock much faster than the serial clock it samples.
*/
// Summary of operation
// RL1: Select low makes the device active, select high deselects it into standby, never deep power-down.
// RL2: The output line floats whenever select is high.
// RL3: Input data is ignored while the device is deselected.
// RL4: A falling select starts an operation and a rising select ends it.
// RL5: A rising select after a program or erase keeps the device active until the internal cycle ends.
// RL6: Command, address and write bits are taken on each rising serial clock edge.
// RL7: Read data changes on each falling serial clock edge.
// RL8: The host sends command and address on the input line in single-line transfers, and write data too except in dual-input program.
// RL9: In dual-output read the input line turns output and two bits leave per falling edge.
// RL10: Clock modes 0 and 3 both work, so the clock may idle low or high while deselected.
// RL11: In dual-input program the output line turns input and two bits enter per rising edge.
// RL12: While pause is low, clock and input are ignored and the output floats, internal cycles go on.
// RL13: The host starts a pause only while selected with the clock low.
// RL14: Each operation starts with an eight-bit command sent most significant bit first, as are address and data.
package sfspi_pkg;
    localparam int CMD_BITS = 8;
    localparam int ADDR_BITS = 24;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_READ_DUAL = 8'h3b;
    localparam logic [7:0] CMD_PROG = 8'h02;
    localparam logic [7:0] CMD_PROG_DUAL = 8'ha2;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [4:0] CNT_RST = 5'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    typedef enum logic [2:0] {sfspi_idle, sfspi_cmd, sfspi_addr, sfspi_rd, sfspi_wr, sfspi_skip} sfspi_state_t;
endpackage

// >>> src/sfspi_sync.sv
/*
 Two-flop synchroniser for one pin level.
 Assumes the pin is asynchronous to core_clk.
*/
module sfspi_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Level
    input wire logic pin_in,
    output logic sync_out
);
    logic meta_reg;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_reg <= pin_in;
            sync_out <= meta_reg;
        end
    end
endmodule // sfspi_sync

// >>> src/sfspi_front_end.sv
/*
 Serial front end of a flash memory: framing, shifting, dual lanes, pause.
 Assumes the array side answers rd_data and the busy level of its internal cycle.
*/
module sfspi_front_end
    import sfspi_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Serial pins
    input wire logic sel_b,
    input wire logic sclk,
    input wire logic pause_b,
    input wire logic serial_in_bidir_line_i,
    output logic serial_in_bidir_line_o,
    output logic serial_in_bidir_line_oe,
    input wire logic serial_out_bidir_line_i,
    output logic serial_out_bidir_line_o,
    output logic serial_out_bidir_line_oe,
    // Array side
    input wire logic [7:0] rd_data,
    input wire logic array_busy,
    output logic [7:0] cmd_reg,
    output logic [sfspi_pkg::ADDR_BITS-1:0] addr_reg,
    output logic addr_valid_reg,
    output logic rd_req_reg,
    output logic [7:0] wr_data_reg,
    output logic wr_strobe_reg,
    output logic op_end_reg,
    output logic active_reg
);
    import sfspi_pkg::*;

    logic sel_s, sclk_s, pause_s, si_s, so_s;
    logic sclk_d_reg, sel_d_reg;
    logic rise, fall, start, stop, run;
    sfspi_state_t state_reg;
    logic [4:0] cnt_reg;
    logic [7:0] sh_reg, out_reg;
    logic dual_reg;

    sfspi_sync #(.RST_VAL(1'b1)) u_sel (.core_clk(core_clk), .rst_b(rst_b), .pin_in(sel_b), .sync_out(sel_s));
    sfspi_sync #(.RST_VAL(1'b0)) u_sclk (.core_clk(core_clk), .rst_b(rst_b), .pin_in(sclk), .sync_out(sclk_s));
    sfspi_sync #(.RST_VAL(1'b1)) u_pause (.core_clk(core_clk), .rst_b(rst_b), .pin_in(pause_b), .sync_out(pause_s));
    sfspi_sync #(.RST_VAL(1'b0)) u_si (.core_clk(core_clk), .rst_b(rst_b),
        .pin_in(serial_in_bidir_line_i), .sync_out(si_s));
    sfspi_sync #(.RST_VAL(1'b0)) u_so (.core_clk(core_clk), .rst_b(rst_b),
        .pin_in(serial_out_bidir_line_i), .sync_out(so_s));

    // Edge finding; clock idle level is free, only edges inside a frame count
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_d_reg <= 1'b0;
            sel_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s; // RL10
            sel_d_reg <= sel_s;
        end
    end
    assign start = sel_d_reg && !sel_s; // RL4
    assign stop = !sel_d_reg && sel_s; // RL4
    assign run = !sel_s && !start && pause_s; // RL3 RL12
    assign rise = run && sclk_s && !sclk_d_reg; // RL6
    assign fall = run && !sclk_s && sclk_d_reg; // RL7

    function automatic logic is_write(input logic [7:0] c);
        return (c == CMD_PROG) || (c == CMD_PROG_DUAL);
    endfunction

    function automatic logic is_dual(input logic [7:0] c);
        return (c == CMD_READ_DUAL) || (c == CMD_PROG_DUAL);
    endfunction

    // Frame sequencer
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= sfspi_idle;
            cnt_reg <= CNT_RST;
            sh_reg <= BYTE_RST;
            cmd_reg <= BYTE_RST;
            addr_reg <= '0;
            addr_valid_reg <= 1'b0;
            dual_reg <= 1'b0;
            wr_data_reg <= BYTE_RST;
            wr_strobe_reg <= 1'b0;
            rd_req_reg <= 1'b0;
        end else begin
            wr_strobe_reg <= 1'b0;
            rd_req_reg <= 1'b0;
            if (sel_s) begin
                state_reg <= sfspi_idle; // RL1
                dual_reg <= 1'b0;
                addr_valid_reg <= 1'b0;
            end else if (start) begin
                state_reg <= sfspi_cmd; // RL4
                cnt_reg <= CNT_RST;
            end else if (rise) begin
                unique case (state_reg)
                    sfspi_cmd: begin
                        sh_reg <= {sh_reg[6:0], si_s}; // RL14 RL8
                        cnt_reg <= cnt_reg + 5'h01;
                        if (cnt_reg == 5'(CMD_BITS - 1)) begin
                            cmd_reg <= {sh_reg[6:0], si_s};
                            cnt_reg <= CNT_RST;
                            state_reg <= sfspi_addr;
                        end
                    end
                    sfspi_addr: begin
                        addr_reg <= {addr_reg[ADDR_BITS-2:0], si_s}; // RL14
                        cnt_reg <= cnt_reg + 5'h01;
                        if (cnt_reg == 5'(ADDR_BITS - 1)) begin
                            cnt_reg <= CNT_RST;
                            addr_valid_reg <= 1'b1;
                            dual_reg <= is_dual(cmd_reg);
                            state_reg <= is_write(cmd_reg) ? sfspi_wr : sfspi_rd;
                            rd_req_reg <= !is_write(cmd_reg);
                        end
                    end
                    sfspi_wr: begin
                        if (dual_reg) begin
                            sh_reg <= {sh_reg[5:0], so_s, si_s}; // RL11
                            cnt_reg <= cnt_reg + 5'h02;
                        end else begin
                            sh_reg <= {sh_reg[6:0], si_s}; // RL6
                            cnt_reg <= cnt_reg + 5'h01;
                        end
                        if (cnt_reg == 5'h07 || (dual_reg && cnt_reg == 5'h06)) begin
                            wr_data_reg <= dual_reg ? {sh_reg[5:0], so_s, si_s} : {sh_reg[6:0], si_s};
                            wr_strobe_reg <= 1'b1;
                            cnt_reg <= CNT_RST;
                        end
                    end
                    sfspi_rd: begin
                        cnt_reg <= cnt_reg;
                    end
                    sfspi_idle, sfspi_skip: begin
                        state_reg <= state_reg;
                    end
                endcase
            end else if (fall && state_reg == sfspi_rd) begin
                cnt_reg <= cnt_reg + (dual_reg ? 5'h02 : 5'h01);
                if (cnt_reg == 5'h07 || (dual_reg && cnt_reg == 5'h06)) begin
                    cnt_reg <= CNT_RST;
                    rd_req_reg <= 1'b1;
                end
            end
        end
    end

    // Read shifter and output drivers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_reg <= BYTE_RST;
            serial_out_bidir_line_o <= 1'b0;
            serial_out_bidir_line_oe <= 1'b0;
            serial_in_bidir_line_o <= 1'b0;
            serial_in_bidir_line_oe <= 1'b0;
        end else begin
            serial_out_bidir_line_oe <= !sel_s && pause_s && state_reg == sfspi_rd; // RL2 RL12
            serial_in_bidir_line_oe <= !sel_s && pause_s && state_reg == sfspi_rd && dual_reg; // RL9
            if (fall && state_reg == sfspi_rd) begin
                if (cnt_reg == CNT_RST) begin
                    if (dual_reg) begin
                        serial_out_bidir_line_o <= rd_data[7]; // RL9
                        serial_in_bidir_line_o <= rd_data[6];
                        out_reg <= {rd_data[5:0], 2'b00};
                    end else begin
                        serial_out_bidir_line_o <= rd_data[7]; // RL7
                        out_reg <= {rd_data[6:0], 1'b0};
                    end
                end else if (dual_reg) begin
                    serial_out_bidir_line_o <= out_reg[7];
                    serial_in_bidir_line_o <= out_reg[6];
                    out_reg <= {out_reg[5:0], 2'b00};
                end else begin
                    serial_out_bidir_line_o <= out_reg[7];
                    out_reg <= {out_reg[6:0], 1'b0};
                end
            end
        end
    end

    // Activity: stays up across select release while an internal cycle runs
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            active_reg <= 1'b0;
            op_end_reg <= 1'b0;
        end else begin
            op_end_reg <= stop; // RL4
            active_reg <= !sel_s || array_busy; // RL1 RL5
        end
    end

    a_float_desel: assert property (@(posedge core_clk) disable iff (!rst_b)
        sel_s |=> !serial_out_bidir_line_oe && !serial_in_bidir_line_oe) else $error("output driven while deselected"); // RL2
    a_no_wr_desel: assert property (@(posedge core_clk) disable iff (!rst_b)
        sel_s |=> !wr_strobe_reg) else $error("write taken while deselected"); // RL3
    a_pause_float: assert property (@(posedge core_clk) disable iff (!rst_b)
        !pause_s |=> !serial_out_bidir_line_oe) else $error("output driven in pause"); // RL12
    a_busy_active: assert property (@(posedge core_clk) disable iff (!rst_b)
        array_busy |=> active_reg) else $error("standby during internal cycle"); // RL5
    a_sel_active: assert property (@(posedge core_clk) disable iff (!rst_b)
        !sel_s |=> active_reg) else $error("inactive while selected"); // RL1
    a_stop_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
        stop |=> op_end_reg ##1 !op_end_reg) else $error("end pulse wrong"); // RL4
    a_out_on_fall: assert property (@(posedge core_clk) disable iff (!rst_b)
        $changed(serial_out_bidir_line_o) |-> $past(fall)) else $error("output changed off falling edge"); // RL7
    a_cmd_on_rise: assert property (@(posedge core_clk) disable iff (!rst_b)
        $changed(cmd_reg) |-> $past(rise)) else $error("command taken off rising edge"); // RL6
    a_dual_lane: assert property (@(posedge core_clk) disable iff (!rst_b)
        serial_in_bidir_line_oe |-> dual_reg && serial_out_bidir_line_oe) else $error("second lane driven outside dual read"); // RL9

    // Last address bit taken on a rising edge
    sequence s_addr_last;
        rise && state_reg == sfspi_addr && cnt_reg == 5'(ADDR_BITS - 1);
    endsequence
    a_addr_done: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_addr_last |=> addr_valid_reg && (rd_req_reg != is_write(cmd_reg))) else $error("address end not flagged"); // RL14
    a_strobe_once: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_strobe_reg |=> !wr_strobe_reg) else $error("write strobe longer than one cycle"); // RL6
    a_strobe_in_wr: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_strobe_reg |-> state_reg == sfspi_wr) else $error("write strobe outside data phase"); // RL6
    a_pause_freeze: assert property (@(posedge core_clk) disable iff (!rst_b)
        !pause_s && !sel_s && !start |=> $stable(cnt_reg) && $stable(state_reg)) else $error("state moved in pause"); // RL12
endmodule // sfspi_front_end

// >>> testbench/sfspi_host_model.sv
/*
 Behavioural SPI host facing the serial flash front end.
 Assumes the bench resolves both data lines and feeds their levels back.
*/
module sfspi_host_model (
    // Clock
    input wire logic core_clk,
    // Resolved line levels
    input wire logic in_line,
    input wire logic out_line,
    // Host drive
    output logic sel_b,
    output logic sclk,
    output logic pause_b,
    output logic si_drv,
    output logic si_en,
    output logic so_drv,
    output logic so_en
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sel_b = 1'b1;
        sclk = 1'b0;
        pause_b = 1'b1;
        si_drv = 1'b0;
        si_en = 1'b1;
        so_drv = 1'b0;
        so_en = 1'b0;
    end
    task automatic start(input logic idle);
        @(posedge core_clk);
        sclk <= idle;
        @(posedge core_clk);
        sel_b <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask
    task automatic stop(input logic idle);
        @(posedge core_clk);
        sclk <= idle;
        repeat (4) @(posedge core_clk);
        sel_b <= 1'b1;
        so_en <= 1'b0;
        @(posedge core_clk);
        si_en <= 1'b1;
    endtask
    // One byte, 64 ns per clock, sampled late in the high half
    task automatic bits(input logic [7:0] tx, input logic two_in, input logic two_out, output logic [7:0] rx);
        int n;
        n = (two_in || two_out) ? 4 : 8;
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            sclk <= 1'b0;
            si_en <= ~two_out;
            so_en <= two_in;
            so_drv <= tx[7 - 2 * i];
            si_drv <= two_in ? tx[6 - 2 * i] : tx[7 - i];
            repeat (4) @(posedge core_clk);
            sclk <= 1'b1;
            repeat (3) @(posedge core_clk);
            @(negedge core_clk);
            rx = two_out ? {rx[5:0], out_line, in_line} : {rx[6:0], out_line};
        end
    endtask
    task automatic wiggle(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge core_clk);
            sclk <= ~sclk;
            si_drv <= 1'($urandom);
        end
    endtask
    task automatic pause_burst();
        @(posedge core_clk);
        sclk <= 1'b0;
        repeat (6) @(posedge core_clk);
        pause_b <= 1'b0;
        wiggle(8);
        repeat (4) @(posedge core_clk);
        pause_b <= 1'b1;
    endtask
endmodule // sfspi_host_model

// >>> testbench/sfspi_front_end_tb.sv
/*
 Self-checking bench for the serial flash front end.
 Assumes the package, the design and the host model are compiled first.
*/
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module sfspi_front_end_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sfspi_pkg::*;
    logic core_clk = 1'b0, noise = 1'b0, rst_b, array_busy, in_line, out_line, in_o, in_oe, out_o, out_oe;
    logic sel_b, sclk, pause_b, si_drv, si_en, so_drv, so_en, addr_valid_reg, rd_req_reg, wr_strobe_reg;
    logic op_end_reg, active_reg;
    logic [7:0] rd_data, cmd_reg, wr_data_reg, cmd, d, rx;
    logic [23:0] addr_reg, addr;
    logic [7:0] wq[$];
    int err_count = 0, n_tests = 0, ends = 0, reqs = 0, seed;
    assign in_line = in_oe ? in_o : (si_en ? si_drv : noise);
    assign out_line = out_oe ? out_o : (so_en ? so_drv : noise);
    initial forever #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        noise <= ~noise;
        if (wr_strobe_reg === 1'b1) wq.push_back(wr_data_reg);
        if (op_end_reg === 1'b1) ends++;
        if (rd_req_reg === 1'b1) reqs++;
    end
    sfspi_host_model host_i (.core_clk(core_clk), .in_line(in_line), .out_line(out_line), .sel_b(sel_b),
        .sclk(sclk), .pause_b(pause_b), .si_drv(si_drv), .si_en(si_en), .so_drv(so_drv), .so_en(so_en));
    sfspi_front_end sfspi_front_end_i (.core_clk(core_clk), .rst_b(rst_b), .sel_b(sel_b), .sclk(sclk),
        .pause_b(pause_b), .serial_in_bidir_line_i(in_line), .serial_in_bidir_line_o(in_o),
        .serial_in_bidir_line_oe(in_oe), .serial_out_bidir_line_i(out_line), .serial_out_bidir_line_o(out_o),
        .serial_out_bidir_line_oe(out_oe), .rd_data(rd_data), .array_busy(array_busy), .cmd_reg(cmd_reg),
        .addr_reg(addr_reg), .addr_valid_reg(addr_valid_reg), .rd_req_reg(rd_req_reg), .wr_data_reg(wr_data_reg),
        .wr_strobe_reg(wr_strobe_reg), .op_end_reg(op_end_reg), .active_reg(active_reg));
    function automatic logic [7:0] addr_byte(logic [23:0] a, int k);
        return a[23 - 8 * k -: 8];
    endfunction
    function automatic logic is_write(logic [7:0] c);
        return c == CMD_PROG || c == CMD_PROG_DUAL;
    endfunction
    task automatic close_out();
        $display("Checks %0d, errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge core_clk);
        err_count++;
        close_out();
    end
    initial begin
        logic [7:0] kinds [4];
        rst_b = 1'b0;
        rd_data = 8'h00;
        array_busy = 1'b0;
        kinds = '{CMD_PROG, CMD_PROG_DUAL, CMD_READ, CMD_READ_DUAL};
        seed = $urandom(32'haf69);
        repeat (8) @(posedge core_clk);
        `CHK({active_reg, out_oe, in_oe, op_end_reg}, 4'h0)
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        host_i.wiggle(12);
        `CHK({cmd_reg, active_reg, out_oe}, 10'h000)
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 4; k++) begin
                reqs = 0;
                cmd = kinds[k];
                addr = 24'($urandom);
                d = 8'($urandom);
                rd_data <= d;
                host_i.start(1'(m));
                host_i.bits(cmd, 1'b0, 1'b0, rx);
                for (int j = 0; j < 3; j++) host_i.bits(addr_byte(addr, j), 1'b0, 1'b0, rx);
                `CHK(cmd_reg, cmd)
                `CHK({addr_valid_reg, addr_reg}, {1'b1, addr})
                wq.delete();
                ends = 0;
                if (is_write(cmd)) begin
                    host_i.bits(d, cmd == CMD_PROG_DUAL, 1'b0, rx);
                    array_busy <= 1'b1;
                end else begin
                    fork
                        host_i.pause_burst();
                        begin repeat (20) @(posedge core_clk); `CHK(out_oe, 1'b0) end
                    join
                    host_i.bits(8'h00, 1'b0, cmd == CMD_READ_DUAL, rx);
                    `CHK(rx, d)
                    `CHK(in_oe, cmd == CMD_READ_DUAL)
                end
                host_i.stop(1'(m));
                repeat (8) @(posedge core_clk);
                `CHK({out_oe, in_oe, active_reg, ends}, {2'b00, is_write(cmd), 32'd1})
                `CHK(reqs, is_write(cmd) ? 0 : 2)
                if (is_write(cmd)) `CHK({wq.size(), wq[0]}, {32'd1, d})
                array_busy <= 1'b0;
                repeat (8) @(posedge core_clk);
                `CHK(active_reg, 1'b0)
            end
        end
        close_out();
    end
endmodule // sfspi_front_end_tb
